// ===== ddc_ovr_ctrl.sv
`timescale 1ns/1ps
// Operation
// - Quarter-rate band select picks 80% or 87.5% alias-protected filter.
// - Half-rate select picks low-pass or high-pass (inverting) decimation.
// - Spectrum flip negates odd samples only when enabled with real output.
// - Final gain adds 6.02 dB in complex modes only.
// - Magnitude at or above level zero sets overrange bit 0.
// - Magnitude at or above level one sets overrange bit 1.
// - Pin enable low holds all four range pins low.
// - Pin enable gates only pins; embedded status always produced.
// - Pin pulses last at least 8 times two to the hold exponent.
// - Hold exponent changes with link enabled may shift period phase.
// - Each DDC has four presets; exactly one active at a time.
// - Source mode 0 takes both presets from the select register.
// - Source mode 1 takes A preset from A pins, B from B pins.
// - Source mode 2 uses A pins for both; mode 3 reserved.
// - Select bits 1-0 choose DDC A preset, bits 3-2 DDC B.
module ddc_ovr_ctrl (
	input  wire logic                             clk,
	input  wire logic                             rst_n,
	input  wire logic [ddc_ovr_pkg::ADDR_W-1:0]   reg_addr,
	input  wire logic [ddc_ovr_pkg::DATA_W-1:0]   reg_wdata,
	input  wire logic                             reg_wr,
	input  wire logic                             reg_rd,
	output logic      [ddc_ovr_pkg::DATA_W-1:0]   reg_rdata,
	input  wire logic                             sample_valid,
	input  wire logic [ddc_ovr_pkg::SAMPLE_W-1:0] sample_a,
	input  wire logic [ddc_ovr_pkg::SAMPLE_W-1:0] sample_b,
	output logic                                  out_valid,
	output logic      [ddc_ovr_pkg::SAMPLE_W+1:0] out_data_a,
	output logic      [ddc_ovr_pkg::SAMPLE_W+1:0] out_data_b,
	output logic                                  quarter_rate_band_select,
	output logic                                  half_rate_highpass_select,
	output logic                                  serial_link_enable,
	input  wire logic [1:0]                       preset_pins_a,
	input  wire logic [1:0]                       preset_pins_b,
	output logic      [1:0]                       active_preset_a,
	output logic      [1:0]                       active_preset_b,
	output logic                                  range_flag_a_zero,
	output logic                                  range_flag_a_one,
	output logic                                  range_flag_b_zero,
	output logic                                  range_flag_b_one,
	output logic                                  irq
);
	import ddc_ovr_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Registers

	logic [7:0] filter_cfg_r;
	logic [7:0] level_zero_r;
	logic [7:0] level_one_r;
	logic [7:0] output_cfg_r;
	logic [7:0] source_mode_r;
	logic [7:0] preset_sel_r;
	logic [7:0] irq_mask_r;
	logic [7:0] path_ctrl_r;
	logic [3:0] irq_status_r;
	logic [3:0] irq_set;
	logic       status_rd;

	logic       final_gain_6db;
	logic       spectrum_flip;
	logic       overrange_pin_enable;
	logic [2:0] overrange_hold_exponent;
	logic [1:0] preset_select_a;
	logic [1:0] preset_select_b;
	logic       ddc_enable;
	logic       complex_out;
	preset_src_t preset_source_mode;

	// Whole bytes are stored, so reserved bits read back unchanged
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			filter_cfg_r  <= RST_FILTER_CFG;
			level_zero_r  <= RST_LEVEL_ZERO;
			level_one_r   <= RST_LEVEL_ONE;
			output_cfg_r  <= RST_OUTPUT_CFG;
			source_mode_r <= RST_SOURCE_MODE;
			preset_sel_r  <= RST_PRESET_SEL;
			irq_mask_r    <= RST_IRQ_MASK;
			path_ctrl_r   <= RST_PATH_CTRL;
		end else if (reg_wr) begin
			if (reg_addr == OFS_FILTER_CFG)
				filter_cfg_r <= reg_wdata;
			else if (reg_addr == OFS_LEVEL_ZERO)
				level_zero_r <= reg_wdata;
			else if (reg_addr == OFS_LEVEL_ONE)
				level_one_r <= reg_wdata;
			else if (reg_addr == OFS_OUTPUT_CFG)
				output_cfg_r <= reg_wdata;
			else if (reg_addr == OFS_SOURCE_MODE)
				source_mode_r <= reg_wdata;
			else if (reg_addr == OFS_PRESET_SEL)
				preset_sel_r <= reg_wdata;
			else if (reg_addr == OFS_IRQ_MASK)
				irq_mask_r <= reg_wdata;
			else if (reg_addr == OFS_PATH_CTRL)
				path_ctrl_r <= reg_wdata;
		end
	end

	// Only the documented fields are decoded
	assign final_gain_6db          = filter_cfg_r[POS_FINAL_GAIN];
	assign spectrum_flip           = filter_cfg_r[POS_FLIP];
	assign overrange_pin_enable    = output_cfg_r[POS_PIN_ENABLE];
	assign overrange_hold_exponent = output_cfg_r[POS_HOLD_EXP +: 3];
	assign preset_select_a         = preset_sel_r[POS_SEL_A +: 2];
	assign preset_select_b         = preset_sel_r[POS_SEL_B +: 2];
	assign preset_source_mode      = preset_src_t'(source_mode_r[1:0]);
	assign ddc_enable              = path_ctrl_r[POS_DDC_ENABLE];
	assign complex_out             = path_ctrl_r[POS_COMPLEX];
	assign serial_link_enable      = path_ctrl_r[POS_LINK_ENABLE];

	// Filter choices go to the decimation chain
	assign quarter_rate_band_select  = filter_cfg_r[POS_QUARTER_BAND];
	assign half_rate_highpass_select = filter_cfg_r[POS_HALF_HP];

	////////////////////////////////////////////////////////////////////////
	// Read port

	assign status_rd = reg_rd && (reg_addr == OFS_IRQ_STATUS);

	always_ff @(posedge clk) begin
		if (!rst_n)
			reg_rdata <= '0;
		else if (!reg_rd)
			reg_rdata <= '0;
		else if (reg_addr == OFS_FILTER_CFG)
			reg_rdata <= filter_cfg_r;
		else if (reg_addr == OFS_LEVEL_ZERO)
			reg_rdata <= level_zero_r;
		else if (reg_addr == OFS_LEVEL_ONE)
			reg_rdata <= level_one_r;
		else if (reg_addr == OFS_OUTPUT_CFG)
			reg_rdata <= output_cfg_r;
		else if (reg_addr == OFS_SOURCE_MODE)
			reg_rdata <= source_mode_r;
		else if (reg_addr == OFS_PRESET_SEL)
			reg_rdata <= preset_sel_r;
		else if (reg_addr == OFS_IRQ_STATUS)
			reg_rdata <= {4'h0, irq_status_r};
		else if (reg_addr == OFS_IRQ_MASK)
			reg_rdata <= irq_mask_r;
		else if (reg_addr == OFS_PATH_CTRL)
			reg_rdata <= path_ctrl_r;
		else
			reg_rdata <= '0;
	end

	////////////////////////////////////////////////////////////////////////
	// Overrange detection

	logic [SAMPLE_W-1:0] mag_a;
	logic [SAMPLE_W-1:0] mag_b;
	logic [8:0]          lvl_a;
	logic [8:0]          lvl_b;
	logic [1:0]          over_a;
	logic [1:0]          over_b;

	// Magnitude on a 256 step full scale; 9 bits so the most negative code
	// still compares above every threshold
	assign mag_a = sample_a[SAMPLE_W-1] ? SAMPLE_W'(-sample_a) : sample_a;
	assign mag_b = sample_b[SAMPLE_W-1] ? SAMPLE_W'(-sample_b) : sample_b;
	assign lvl_a = mag_a[SAMPLE_W-1:SAMPLE_W-9];
	assign lvl_b = mag_b[SAMPLE_W-1:SAMPLE_W-9];

	assign over_a[0] = sample_valid && (lvl_a >= {1'b0, level_zero_r});
	assign over_b[0] = sample_valid && (lvl_b >= {1'b0, level_zero_r});
	assign over_a[1] = sample_valid && (lvl_a >= {1'b0, level_one_r});
	assign over_b[1] = sample_valid && (lvl_b >= {1'b0, level_one_r});

	////////////////////////////////////////////////////////////////////////
	// Output sample path

	logic                odd_r;
	logic                gain_on;
	logic                flip_on;
	logic [SAMPLE_W-1:0] proc_a;
	logic [SAMPLE_W-1:0] proc_b;

	function automatic logic [SAMPLE_W-1:0] shape(
		input logic [SAMPLE_W-1:0] s,
		input logic                dbl,
		input logic                neg
	);
		logic [SAMPLE_W-1:0] v;
		v = s;
		if (dbl) begin
			// Saturate rather than wrap when the doubled value overflows
			if (s[SAMPLE_W-1] != s[SAMPLE_W-2])
				v = s[SAMPLE_W-1] ? {1'b1, {(SAMPLE_W-1){1'b0}}}
				                  : {1'b0, {(SAMPLE_W-1){1'b1}}};
			else
				v = {s[SAMPLE_W-2:0], 1'b0};
		end
		if (neg) begin
			// The most negative code has no positive twin; clamp it
			if (v == {1'b1, {(SAMPLE_W-1){1'b0}}})
				v = {1'b0, {(SAMPLE_W-1){1'b1}}};
			else
				v = SAMPLE_W'(-v);
		end
		return v;
	endfunction

	assign gain_on = ddc_enable && complex_out && final_gain_6db;
	assign flip_on = ddc_enable && !complex_out && spectrum_flip && odd_r;
	assign proc_a  = shape(sample_a, gain_on, flip_on);
	assign proc_b  = shape(sample_b, gain_on, flip_on);

	// Sample parity for the flip, counted over valid samples
	always_ff @(posedge clk) begin
		if (!rst_n)
			odd_r <= 1'b0;
		else if (sample_valid)
			odd_r <= !odd_r;
	end

	// Embedded status travels with the data whatever the pin enable
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			out_valid  <= 1'b0;
			out_data_a <= '0;
			out_data_b <= '0;
		end else begin
			out_valid <= sample_valid;
			if (sample_valid) begin
				out_data_a <= {over_a, proc_a};
				out_data_b <= {over_b, proc_b};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pulse stretching for the range pins

	logic [3:0] over_all;
	logic [3:0] held;

	assign over_all = {over_b, over_a};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_hold
			hold_if hb ();
			assign hb.trig   = over_all[gi];
			// Exponent is applied at each reload, so a change while the link
			// runs moves where pulses end
			assign hb.expo   = overrange_hold_exponent;
			assign held[gi]  = hb.flag;
			range_hold #(
				.CNT_W (HOLD_W)
			) u_hold (
				.clk   (clk),
				.rst_n (rst_n),
				.hp    (hb.hold)
			);
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			range_flag_a_zero <= 1'b0;
			range_flag_a_one  <= 1'b0;
			range_flag_b_zero <= 1'b0;
			range_flag_b_one  <= 1'b0;
		end else begin
			range_flag_a_zero <= overrange_pin_enable && held[0];
			range_flag_a_one  <= overrange_pin_enable && held[1];
			range_flag_b_zero <= overrange_pin_enable && held[2];
			range_flag_b_one  <= overrange_pin_enable && held[3];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt status

	assign irq_set = over_all;

	// A new event in the cycle of the clearing read is kept
	always_ff @(posedge clk) begin
		if (!rst_n)
			irq_status_r <= '0;
		else if (status_rd)
			irq_status_r <= irq_set;
		else
			irq_status_r <= irq_status_r | irq_set;
	end

	assign irq = |(irq_status_r & irq_mask_r[3:0]);

	////////////////////////////////////////////////////////////////////////
	// Preset selection

	logic [1:0] pins_a_meta;
	logic [1:0] pins_a_sync;
	logic [1:0] pins_b_meta;
	logic [1:0] pins_b_sync;

	// Pins come from outside; two stages before use
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pins_a_meta <= '0;
			pins_a_sync <= '0;
			pins_b_meta <= '0;
			pins_b_sync <= '0;
		end else begin
			pins_a_meta <= preset_pins_a;
			pins_a_sync <= pins_a_meta;
			pins_b_meta <= preset_pins_b;
			pins_b_sync <= pins_b_meta;
		end
	end

	// One registered index per DDC, so one preset is active at a time
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			active_preset_a <= '0;
			active_preset_b <= '0;
		end else begin
			case (preset_source_mode)
				SRC_REGISTER: begin
					active_preset_a <= preset_select_a;
					active_preset_b <= preset_select_b;
				end
				SRC_PINS_EACH: begin
					active_preset_a <= pins_a_sync;
					active_preset_b <= pins_b_sync;
				end
				SRC_PINS_A: begin
					active_preset_a <= pins_a_sync;
					active_preset_b <= pins_a_sync;
				end
				default: begin
					// Reserved code keeps the last selection
					active_preset_a <= active_preset_a;
					active_preset_b <= active_preset_b;
				end
			endcase
		end
	end

endmodule

// ===== ddc_ovr_pkg.sv
package ddc_ovr_pkg;

	localparam int ADDR_W   = 10;
	localparam int DATA_W   = 8;
	localparam int SAMPLE_W = 12;
	localparam int HOLD_W   = 11;

	// Register offsets
	localparam logic [9:0] OFS_FILTER_CFG  = 10'h210;
	localparam logic [9:0] OFS_LEVEL_ZERO  = 10'h211;
	localparam logic [9:0] OFS_LEVEL_ONE   = 10'h212;
	localparam logic [9:0] OFS_OUTPUT_CFG  = 10'h213;
	localparam logic [9:0] OFS_SOURCE_MODE = 10'h214;
	localparam logic [9:0] OFS_PRESET_SEL  = 10'h215;
	localparam logic [9:0] OFS_IRQ_STATUS  = 10'h21a;
	localparam logic [9:0] OFS_IRQ_MASK    = 10'h21b;
	localparam logic [9:0] OFS_PATH_CTRL   = 10'h21c;

	// Reset values
	localparam logic [7:0] RST_FILTER_CFG  = 8'h00;
	localparam logic [7:0] RST_LEVEL_ZERO  = 8'hf2;
	localparam logic [7:0] RST_LEVEL_ONE   = 8'hab;
	localparam logic [7:0] RST_OUTPUT_CFG  = 8'h07;
	localparam logic [7:0] RST_SOURCE_MODE = 8'h00;
	localparam logic [7:0] RST_PRESET_SEL  = 8'h00;
	localparam logic [7:0] RST_IRQ_MASK    = 8'h00;
	localparam logic [7:0] RST_PATH_CTRL   = 8'h00;

	// Field positions
	localparam int POS_FINAL_GAIN   = 0;
	localparam int POS_FLIP         = 1;
	localparam int POS_HALF_HP      = 2;
	localparam int POS_QUARTER_BAND = 3;
	localparam int POS_PIN_ENABLE   = 3;
	localparam int POS_HOLD_EXP     = 0;
	localparam int POS_SEL_A        = 0;
	localparam int POS_SEL_B        = 2;
	localparam int POS_DDC_ENABLE   = 0;
	localparam int POS_COMPLEX      = 1;
	localparam int POS_LINK_ENABLE  = 2;

	// Least stretch in clock cycles, scaled by two to the exponent
	localparam logic [10:0] HOLD_BASE = 11'h008;

	typedef enum logic [1:0] {
		SRC_REGISTER = 2'b00,
		SRC_PINS_EACH = 2'b01,
		SRC_PINS_A    = 2'b10,
		SRC_RESERVED  = 2'b11
	} preset_src_t;

endpackage

// ===== ddc_ovr_sva.sv
`timescale 1ns/1ps
module ddc_ovr_sva
	import ddc_ovr_pkg::*;
(
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic [9:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       sample_valid,
	input wire logic       out_valid,
	input wire logic [1:0] preset_pins_a,
	input wire logic [1:0] preset_pins_b,
	input wire logic [1:0] active_preset_a,
	input wire logic [1:0] active_preset_b,
	input wire logic       range_flag_a_zero,
	input wire logic       range_flag_b_one
);
	logic       en_r;
	logic [1:0] mode_r;
	logic [3:0] sel_r;
	// Shadow of the fields that steer pins and presets
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			en_r   <= 1'b0;
			mode_r <= 2'h0;
			sel_r  <= 4'h0;
		end else if (reg_wr) begin
			if (reg_addr == OFS_OUTPUT_CFG)
				en_r <= reg_wdata[3];
			if (reg_addr == OFS_SOURCE_MODE)
				mode_r <= reg_wdata[1:0];
			if (reg_addr == OFS_PRESET_SEL)
				sel_r <= reg_wdata[3:0];
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	////////////////
	property p_rd_idle;
		!$past(reg_rd) |-> reg_rdata == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
	property p_valid;
		sample_valid |=> out_valid;
	endproperty
	a_valid: assert property (p_valid) else $error("out_valid missing");
	property p_gate;
		!$past(en_r) && !$past(en_r, 2) |-> !range_flag_a_zero && !range_flag_b_one;
	endproperty
	a_gate: assert property (p_gate) else $error("pin while disabled");
	property p_rise;
		$rose(range_flag_a_zero) && $past(en_r) && $past(en_r, 2)
			|-> $past(sample_valid, 2);
	endproperty
	a_rise: assert property (p_rise) else $error("pin without sample");
	// Enable may cut a pulse short, so a cleared enable excuses a low pin
	property p_stretch;
		$rose(range_flag_b_one) && en_r
			|-> (range_flag_b_one || !en_r || !$past(en_r))[*8];
	endproperty
	a_stretch: assert property (p_stretch) else $error("pulse short");
	property p_reg_sel;
		mode_r == 2'h0 && $stable(mode_r) && $stable(sel_r)
			|-> active_preset_a == sel_r[1:0] && active_preset_b == sel_r[3:2];
	endproperty
	a_reg_sel: assert property (p_reg_sel) else $error("reg preset");
	property p_pin_each;
		(mode_r == 2'h1 && $stable(preset_pins_a) && $stable(preset_pins_b))[*4]
			|-> active_preset_a == preset_pins_a
			&& active_preset_b == preset_pins_b;
	endproperty
	a_pin_each: assert property (p_pin_each) else $error("pin preset");
	property p_pin_a;
		(mode_r == 2'h2 && $stable(preset_pins_a))[*4]
			|-> active_preset_a == preset_pins_a
			&& active_preset_b == preset_pins_a;
	endproperty
	a_pin_a: assert property (p_pin_a) else $error("shared preset");
endmodule
bind ddc_ovr_ctrl ddc_ovr_sva chk_i (
	.clk,
	.rst_n,
	.reg_addr,
	.reg_wdata,
	.reg_wr,
	.reg_rd,
	.reg_rdata,
	.sample_valid,
	.out_valid,
	.preset_pins_a,
	.preset_pins_b,
	.active_preset_a,
	.active_preset_b,
	.range_flag_a_zero,
	.range_flag_b_one
);

// ===== hold_if.sv
`timescale 1ns/1ps
interface hold_if;
	logic       trig;
	logic [2:0] expo;
	logic       flag;
	modport ctrl (output trig, output expo, input flag);
	modport hold (input trig, input expo, output flag);
endinterface

// ===== preset_host.sv
`timescale 1ns/1ps
module preset_host (
	input  wire logic       clk,
	input  wire logic [1:0] want_a,
	input  wire logic [1:0] want_b,
	output logic      [1:0] preset_pins_a,
	output logic      [1:0] preset_pins_b
);
	// Pins move just after an edge, as a clocked host would drive them
	always @(posedge clk) begin
		preset_pins_a <= want_a;
		preset_pins_b <= want_b;
	end
endmodule

// ===== range_hold.sv
`timescale 1ns/1ps
module range_hold #(
	parameter int CNT_W = 11
) (
	input  wire logic clk,
	input  wire logic rst_n,
	hold_if.hold      hp
);
	import ddc_ovr_pkg::*;

	logic [CNT_W-1:0] count_r;

	if (CNT_W < HOLD_W) begin : g_width_check
		$error("range_hold: counter too narrow for longest stretch");
	end

	// A new event restarts the stretch, so the pulse lasts at least the full
	// period after the last detection
	always_ff @(posedge clk) begin
		if (!rst_n)
			count_r <= '0;
		else if (hp.trig)
			count_r <= CNT_W'(HOLD_BASE << hp.expo);
		else if (count_r != '0)
			count_r <= count_r - CNT_W'(1);
	end

	assign hp.flag = (count_r != '0);
endmodule

// ===== testbench.sv
`timescale 1ns/1ps
module testbench;
	import ddc_ovr_pkg::*;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [9:0]  reg_addr = 10'h000;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        sample_valid = 1'b0;
	logic [11:0] sample_a = 12'h000;
	logic [11:0] sample_b = 12'h000;
	logic [1:0]  want_a = 2'h0;
	logic [1:0]  want_b = 2'h0;
	logic [7:0]  reg_rdata, v;
	logic [13:0] out_data_a, out_data_b, oa, ob;
	logic [1:0]  pins_a, pins_b, act_a, act_b;
	logic [3:0]  flags;
	logic        out_valid, qband, hpass, link, irq;
	logic [15:0] cnt [4];
	int          error_cnt = 0;
	int          checks = 0;
	always #12.5 clk = ~clk;
	preset_host host (.clk, .want_a, .want_b,
		.preset_pins_a(pins_a), .preset_pins_b(pins_b));
	ddc_ovr_ctrl DUT (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .sample_valid, .sample_a, .sample_b, .out_valid,
		.out_data_a, .out_data_b, .quarter_rate_band_select(qband),
		.half_rate_highpass_select(hpass), .serial_link_enable(link),
		.preset_pins_a(pins_a), .preset_pins_b(pins_b),
		.active_preset_a(act_a), .active_preset_b(act_b),
		.range_flag_a_zero(flags[0]), .range_flag_a_one(flags[1]),
		.range_flag_b_zero(flags[2]), .range_flag_b_one(flags[3]), .irq);
	////////////////
	task chk(input logic [15:0] e, input logic [15:0] s, input string n);
		checks++;
		if (s !== e) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task wr(input logic [9:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask
	task rd(input logic [9:0] a);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		v = reg_rdata;
		@(posedge clk);
	endtask
	task smp(input logic [11:0] a, input logic [11:0] b);
		sample_a <= a;
		sample_b <= b;
		sample_valid <= 1'b1;
		@(posedge clk);
		sample_valid <= 1'b0;
		@(negedge clk);
		oa = out_data_a;
		ob = out_data_b;
		chk(1'b1, out_valid, "out valid");
		@(posedge clk);
	endtask
	// Counts high cycles of each range pin over a fixed window
	task watch(input int w);
		cnt = '{default: 16'h0000};
		repeat (w) begin
			@(negedge clk);
			for (int i = 0; i < 4; i++)
				cnt[i] += {15'h0000, flags[i]};
		end
		@(posedge clk);
	endtask
	////////////////
	task t_regs;
		logic [9:0] ad [7] = '{OFS_FILTER_CFG, OFS_LEVEL_ZERO, OFS_LEVEL_ONE,
			OFS_OUTPUT_CFG, OFS_SOURCE_MODE, OFS_PRESET_SEL, 10'h2ff};
		logic [7:0] rv [7] = '{8'h00, 8'hf2, 8'hab, 8'h07, 8'h00, 8'h00, 8'h00};
		for (int i = 0; i < 7; i++) begin
			rd(ad[i]);
			chk(rv[i], v, "reset value");
		end
		wr(OFS_FILTER_CFG, 8'hf8);
		chk(2'b10, {qband, hpass}, "band selects");
		rd(OFS_FILTER_CFG);
		chk(8'hf8, v, "reserved readback");
		wr(OFS_FILTER_CFG, 8'h04);
		chk(2'b01, {qband, hpass}, "band selects");
		wr(10'h2ff, 8'h55);
		wr(OFS_IRQ_STATUS, 8'hff);
		rd(OFS_IRQ_STATUS);
		chk(8'h00, v, "status read only");
		rd(10'h2ff);
		chk(8'h00, v, "unmapped read");
		wr(OFS_PATH_CTRL, 8'h04);
		chk(1'b1, link, "link enable");
		wr(OFS_PATH_CTRL, 8'h00);
	endtask
	task t_flip;
		wr(OFS_PATH_CTRL, 8'h01);
		wr(OFS_FILTER_CFG, 8'h02);
		smp(12'd100, 12'd5);
		chk(12'd100, oa[11:0], "even sample");
		smp(12'd100, 12'd5);
		chk(12'hf9c, oa[11:0], "odd sample a");
		chk(12'hffb, ob[11:0], "odd sample b");
		smp(12'h800, 12'h000);
		smp(12'h800, 12'h000);
		chk(12'h7ff, oa[11:0], "odd full scale");
		wr(OFS_PATH_CTRL, 8'h03);
		wr(OFS_FILTER_CFG, 8'h03); // Image assumed filtered here
		smp(12'd300, 12'd1500);
		chk(12'h258, oa[11:0], "gain");
		chk(12'h7ff, ob[11:0], "gain clip");
		smp(12'd300, 12'd0);
		chk(12'h258, oa[11:0], "complex no flip");
		wr(OFS_PATH_CTRL, 8'h01);
		wr(OFS_FILTER_CFG, 8'h01);
		smp(12'd300, 12'd0);
		chk(12'd300, oa[11:0], "real no gain");
	endtask
	task t_detect;
		wr(OFS_LEVEL_ZERO, 8'h10);
		wr(OFS_LEVEL_ONE, 8'h20);
		wr(OFS_OUTPUT_CFG, 8'h08); // Link stays off while hold changes
		wr(OFS_IRQ_MASK, 8'h0f);
		rd(OFS_IRQ_STATUS);
		smp(12'd128, 12'hf00);
		chk(2'b01, oa[13:12], "status a");
		chk(2'b11, ob[13:12], "status b");
		chk(1'b1, irq, "irq raised");
		watch(30);
		chk(16'd8, cnt[0], "pulse a0");
		chk(16'd0, cnt[1], "pulse a1");
		chk(16'd8, cnt[2], "pulse b0");
		chk(16'd8, cnt[3], "pulse b1");
		rd(OFS_IRQ_STATUS);
		chk(8'h0d, v, "irq status");
		chk(1'b0, irq, "irq cleared");
		wr(OFS_IRQ_MASK, 8'h00);
		smp(12'd127, 12'hf80);
		chk(2'b00, oa[13:12], "below level");
		chk(2'b01, ob[13:12], "at level");
		chk(1'b0, irq, "irq masked");
		rd(OFS_IRQ_STATUS);
		chk(8'h04, v, "masked status");
		wr(OFS_OUTPUT_CFG, 8'h0a);
		smp(12'd0, 12'd256);
		watch(50);
		chk(16'd32, cnt[3], "pulse exp 2");
		wr(OFS_OUTPUT_CFG, 8'h02);
		smp(12'd300, 12'd0);
		chk(2'b11, oa[13:12], "embedded status");
		watch(50);
		chk(16'd0, cnt[0], "gated pin");
	endtask
	task t_presets;
		wr(OFS_PRESET_SEL, 8'h0e);
		// Active preset follows the select register one edge later
		@(posedge clk);
		chk(4'he, {act_b, act_a}, "register preset");
		want_a <= 2'h1;
		want_b <= 2'h2;
		wr(OFS_SOURCE_MODE, 8'h01);
		repeat (6) @(posedge clk);
		chk(4'h9, {act_b, act_a}, "pin preset");
		want_a <= 2'h3;
		wr(OFS_SOURCE_MODE, 8'h02);
		repeat (6) @(posedge clk);
		chk(4'hf, {act_b, act_a}, "shared preset");
		wr(OFS_SOURCE_MODE, 8'h03);
		want_a <= 2'h0;
		repeat (6) @(posedge clk);
		chk(4'hf, {act_b, act_a}, "reserved mode");
		wr(OFS_SOURCE_MODE, 8'hf0);
		rd(OFS_SOURCE_MODE);
		chk(8'hf0, v, "mode readback");
		chk(4'he, {act_b, act_a}, "back to register");
	endtask
	task summarize;
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_regs;
		// Detection first: earlier samples would leave long stretches pending
		t_detect;
		t_flip;
		t_presets;
		summarize;
	end
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		summarize;
	end
endmodule
